// ---- core/ims_cdc_sync.sv ----
// two-flop synchroniser for a vector of levels or toggles
// assumes: each input bit changes at most once per few destination cycles
`timescale 1ns/1ns
`default_nettype none
module ims_cdc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level,
	output logic [W-1:0] pulse
);
	import ims_pkg::*;

	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] seen;

	assign level = stable;
	// toggle edge becomes a one-cycle pulse
	assign pulse = stable ^ seen;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			stable <= '0;
			seen <= '0;
		end else begin
			meta <= async_in;
			stable <= meta;
			seen <= stable;
		end
	end

endmodule : ims_cdc_sync
`default_nettype wire

// ---- core/ims_core.sv ----
// i2c master sequencer: software side on mclk, bus engine on link_clk
// assumes: open-drain pads resolve scl/sda from the enables, pull-ups fitted
`timescale 1ns/1ns
`default_nettype none
module ims_core #(
	parameter int RATE_W = ims_pkg::RATE_W
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic port_enable_bit,
	input wire logic [ims_pkg::MODE_W-1:0] mode_select_bits,
	input wire logic [RATE_W-1:0] rate_reload_value,
	input wire logic control_two_wr,
	input wire logic [ims_pkg::CTL2_LOW_W-1:0] control_two_wdata,
	input wire logic shift_buffer_wr,
	input wire logic [ims_pkg::BYTE_W-1:0] shift_buffer_wdata,
	input wire logic serial_irq_clr,
	input wire logic write_collision_clr,
	input wire logic bus_collision_clr,
	input wire logic fw_scl_low,
	input wire logic fw_sda_low,
	output logic serial_irq_flag,
	output logic write_collision_flag,
	output logic bus_collision_flag,
	output logic begin_detected,
	output logic halt_detected,
	output logic buffer_full,
	output logic ack_result,
	output logic start_trigger,
	output logic restart_trigger,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe
);
	import ims_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE,
		S_ST_WAIT,
		S_ST_CHK,
		S_ST_LOW,
		S_RS_SCLLO,
		S_RS_SDAHI,
		S_RS_SCLREL,
		S_RS_BOTHHI,
		S_RS_LOW,
		S_TX_DROP,
		S_TX_LOW,
		S_TX_REL,
		S_TX_HIGH,
		S_ABORT
	} ims_state_t;

	// ****************************************
	// software side decode (mclk)
	// ****************************************
	logic pending;
	logic cmd_tgl;
	ims_cmd_t cmd_kind;
	logic [BYTE_W-1:0] cmd_data;
	logic [RATE_W-1:0] cmd_reload;
	logic [EV_N-1:0] ev_tgl;
	logic [EV_N-1:0] ev_pulse;
	logic res_coll;
	logic res_ack;

	wire en_master = port_enable_bit && (mode_select_bits == MODE_MASTER);
	wire en_fw = port_enable_bit && (mode_select_bits == MODE_FW_MASTER);
	wire cmd_free = en_master && !pending;
	wire start_wr = control_two_wr && control_two_wdata[CTL2_START];
	wire restart_wr = control_two_wr && control_two_wdata[CTL2_RESTART];
	// control two low field only acts when nothing is pending
	wire take_start = start_wr && cmd_free;
	wire take_restart = restart_wr && !start_wr && cmd_free;
	wire take_tx = shift_buffer_wr && cmd_free && !control_two_wr;
	wire take_cmd = take_start || take_restart || take_tx;
	// buffer write while any sequence runs is dropped
	wire write_collision_flag_hit = shift_buffer_wr && en_master && !take_tx;
	wire done_ev = ev_pulse[EV_DONE] && pending;
	wire done_ok = done_ev && !res_coll;
	wire done_bad = done_ev && res_coll;
	// master irq from collision-free start, restart or byte completion, detect irq only in firmware mode
	wire irq_set = done_ok || (en_fw && (ev_pulse[EV_BEGIN] || ev_pulse[EV_HALT]));
	wire next_irq = irq_set || (serial_irq_flag && !serial_irq_clr);
	wire next_write_collision_flag = write_collision_flag_hit || (write_collision_flag && !write_collision_clr);
	wire next_bcol = done_bad || (bus_collision_flag && !bus_collision_clr);

	assign start_trigger = pending && (cmd_kind == CMD_START);
	assign restart_trigger = pending && (cmd_kind == CMD_RESTART);

	// ****************************************
	// command register and flags (mclk)
	// ****************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pending <= 1'b0;
			cmd_tgl <= 1'b0;
			cmd_kind <= CMD_START;
			cmd_data <= BYTE_RST;
			cmd_reload <= RELOAD_RST;
		end else begin
			if (!en_master) begin
				pending <= 1'b0;
			end else if (take_cmd) begin
				pending <= 1'b1;
			end else if (done_ev) begin
				pending <= 1'b0;
			end
			if (take_cmd) begin
				cmd_tgl <= ~cmd_tgl;
				cmd_data <= shift_buffer_wdata;
				cmd_reload <= rate_reload_value;
			end
			if (take_start) begin
				cmd_kind <= CMD_START;
			end else if (take_restart) begin
				cmd_kind <= CMD_RESTART;
			end else if (take_tx) begin
				cmd_kind <= CMD_TX;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_irq_flag <= 1'b0;
			write_collision_flag <= 1'b0;
			bus_collision_flag <= 1'b0;
		end else begin
			serial_irq_flag <= next_irq;
			write_collision_flag <= next_write_collision_flag;
			bus_collision_flag <= next_bcol;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			begin_detected <= 1'b0;
			halt_detected <= 1'b0;
		end else if (!port_enable_bit) begin
			begin_detected <= 1'b0;
			halt_detected <= 1'b0;
		end else if (ev_pulse[EV_BEGIN]) begin
			begin_detected <= 1'b1;
			halt_detected <= 1'b0;
		end else if (ev_pulse[EV_HALT]) begin
			begin_detected <= 1'b0;
			halt_detected <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			buffer_full <= 1'b0;
			ack_result <= 1'b0;
		end else begin
			if (!en_master) begin
				buffer_full <= 1'b0;
			end else if (take_tx) begin
				buffer_full <= 1'b1;
			end else if (ev_pulse[EV_BF]) begin
				buffer_full <= 1'b0;
			end
			if (done_ok && (cmd_kind == CMD_TX)) begin
				ack_result <= res_ack;
			end
		end
	end

	ims_cdc_sync #(
		.W(EV_N)
	) u_ev_sync (
		.clk(mclk),
		.rst(sys_rst),
		.async_in(ev_tgl),
		.level(),
		.pulse(ev_pulse)
	);

	// ****************************************
	// link domain reset and crossings
	// ****************************************
	logic lrst_meta;
	logic link_rst;
	logic [LV_N-1:0] lv_in;
	logic [LV_N-1:0] lv;
	logic cmd_pulse;

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lrst_meta <= 1'b1;
			link_rst <= 1'b1;
		end else begin
			lrst_meta <= 1'b0;
			link_rst <= lrst_meta;
		end
	end

	assign lv_in[LV_MASTER] = en_master;
	assign lv_in[LV_FW] = en_fw;
	assign lv_in[LV_FW_SCL] = fw_scl_low;
	assign lv_in[LV_FW_SDA] = fw_sda_low;

	ims_cdc_sync #(
		.W(LV_N)
	) u_lv_sync (
		.clk(link_clk),
		.rst(link_rst),
		.async_in(lv_in),
		.level(lv),
		.pulse()
	);

	ims_cdc_sync #(
		.W(1)
	) u_cmd_sync (
		.clk(link_clk),
		.rst(link_rst),
		.async_in(cmd_tgl),
		.level(),
		.pulse(cmd_pulse)
	);

	// ****************************************
	// pin input filters (link_clk)
	// ****************************************
	logic [1:0] pin_raw;
	logic [1:0] pin_filt;
	assign pin_raw = {sda_in, scl_in};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			logic p1;
			logic p2;
			logic p3;
			always_ff @(posedge link_clk or posedge link_rst) begin
				if (link_rst) begin
					p1 <= 1'b1;
					p2 <= 1'b1;
					p3 <= 1'b1;
					pin_filt[gi] <= 1'b1;
				end else begin
					p1 <= pin_raw[gi];
					p2 <= p1;
					p3 <= p2;
					if (p2 == p3) begin
						pin_filt[gi] <= p2;
					end
				end
			end
		end
	endgenerate

	wire scl_s = pin_filt[0];
	wire sda_s = pin_filt[1];

	// ****************************************
	// start and stop detection (link_clk)
	// ****************************************
	logic sda_prev;
	logic begin_tgl;
	logic halt_tgl;
	wire det_on = lv[LV_MASTER] || lv[LV_FW];
	wire seen_start = det_on && scl_s && sda_prev && !sda_s;
	wire seen_stop = det_on && scl_s && !sda_prev && sda_s;

	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			sda_prev <= 1'b1;
			begin_tgl <= 1'b0;
			halt_tgl <= 1'b0;
		end else begin
			sda_prev <= sda_s;
			begin_tgl <= begin_tgl ^ seen_start;
			halt_tgl <= halt_tgl ^ seen_stop;
		end
	end

	// ****************************************
	// bus engine (link_clk)
	// ****************************************
	ims_state_t state;
	logic scl_low;
	logic sda_low;
	logic [BYTE_W-1:0] shreg;
	logic [BITCNT_W-1:0] bit_cnt;
	logic done_tgl;
	logic bf_tgl;
	logic rc_load;
	logic rc_tick;

	wire cmd_go = cmd_pulse && lv[LV_MASTER];
	wire last_slot = (bit_cnt == ACK_SLOT);

	assign ev_tgl[EV_DONE] = done_tgl;
	assign ev_tgl[EV_BEGIN] = begin_tgl;
	assign ev_tgl[EV_HALT] = halt_tgl;
	assign ev_tgl[EV_BF] = bf_tgl;

	ims_rate_counter #(
		.W(RATE_W)
	) u_rate (
		.link_clk(link_clk),
		.link_rst(link_rst),
		.load(rc_load),
		.load_value(cmd_reload),
		.tick(rc_tick)
	);

	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			state <= S_IDLE;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			shreg <= BYTE_RST;
			bit_cnt <= BITCNT_RST;
			res_coll <= 1'b0;
			res_ack <= 1'b1;
			done_tgl <= 1'b0;
			bf_tgl <= 1'b0;
			rc_load <= 1'b0;
		end else if (!lv[LV_MASTER]) begin
			state <= S_IDLE;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			rc_load <= 1'b0;
		end else begin
			rc_load <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (cmd_go) begin
						res_coll <= 1'b0;
						unique case (cmd_kind)
							CMD_START: begin
								if (scl_s && sda_s) begin
									rc_load <= 1'b1;
									state <= S_ST_CHK;
								end else if (!scl_s && !sda_s) begin
									state <= S_ABORT;
								end else begin
									state <= S_ST_WAIT;
								end
							end
							CMD_RESTART: begin
								scl_low <= 1'b1;
								state <= S_RS_SCLLO;
							end
							CMD_TX: begin
								shreg <= cmd_data;
								bit_cnt <= BITCNT_RST;
								scl_low <= 1'b1;
								state <= S_TX_DROP;
							end
							default: begin
								state <= S_IDLE;
							end
						endcase
					end
				end
				S_ST_WAIT: begin
					if (scl_s && sda_s) begin
						rc_load <= 1'b1;
						state <= S_ST_CHK;
					end else if (!scl_s && !sda_s) begin
						state <= S_ABORT;
					end
				end
				S_ST_CHK: begin
					if (!scl_s) begin
						state <= S_ABORT;
					end else if (rc_tick) begin
						if (sda_s) begin
							sda_low <= 1'b1;
							rc_load <= 1'b1;
							state <= S_ST_LOW;
						end else begin
							state <= S_ABORT;
						end
					end
				end
				S_ST_LOW: begin
					if (rc_tick) begin
						done_tgl <= ~done_tgl;
						state <= S_IDLE;
					end
				end
				S_RS_SCLLO: begin
					if (!scl_s) begin
						sda_low <= 1'b0;
						rc_load <= 1'b1;
						state <= S_RS_SDAHI;
					end
				end
				S_RS_SDAHI: begin
					if (rc_tick) begin
						if (sda_s) begin
							scl_low <= 1'b0;
							state <= S_RS_SCLREL;
						end else begin
							state <= S_ABORT;
						end
					end
				end
				S_RS_SCLREL: begin
					if (scl_s) begin
						if (!sda_s) begin
							state <= S_ABORT;
						end else begin
							rc_load <= 1'b1;
							state <= S_RS_BOTHHI;
						end
					end
				end
				S_RS_BOTHHI: begin
					if (!scl_s || !sda_s) begin
						state <= S_ABORT;
					end else if (rc_tick) begin
						sda_low <= 1'b1;
						rc_load <= 1'b1;
						state <= S_RS_LOW;
					end
				end
				S_RS_LOW: begin
					if (rc_tick) begin
						scl_low <= 1'b1;
						done_tgl <= ~done_tgl;
						state <= S_IDLE;
					end
				end
				S_TX_DROP: begin
					if (!scl_s) begin
						sda_low <= last_slot ? 1'b0 : ~shreg[BYTE_W-1];
						shreg <= {shreg[BYTE_W-2:0], 1'b0};
						bf_tgl <= bf_tgl ^ last_slot;
						rc_load <= 1'b1;
						state <= S_TX_LOW;
					end
				end
				S_TX_LOW: begin
					if (rc_tick) begin
						scl_low <= 1'b0;
						state <= S_TX_REL;
					end
				end
				S_TX_REL: begin
					if (scl_s) begin
						if (last_slot) begin
							res_ack <= sda_s;
						end
						rc_load <= 1'b1;
						state <= S_TX_HIGH;
					end
				end
				S_TX_HIGH: begin
					if (rc_tick) begin
						scl_low <= 1'b1;
						if (last_slot) begin
							done_tgl <= ~done_tgl;
							state <= S_IDLE;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							state <= S_TX_DROP;
						end
					end
				end
				S_ABORT: begin
					res_coll <= 1'b1;
					scl_low <= 1'b0;
					sda_low <= 1'b0;
					done_tgl <= ~done_tgl;
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// pad drive (link_clk)
	// ****************************************
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_oe <= lv[LV_FW] ? lv[LV_FW_SCL] : scl_low;
			sda_oe <= lv[LV_FW] ? lv[LV_FW_SDA] : sda_low;
		end
	end

endmodule : ims_core
`default_nettype wire

// ---- core/ims_rate_counter.sv ----
// baud-rate counter: counts a loaded value down to zero, then stops
// assumes: load is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module ims_rate_counter #(
	parameter int W = ims_pkg::RATE_W
) (
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	output logic tick
);
	import ims_pkg::*;

	logic [W-1:0] count;
	logic running;

	// one tick per count-to-zero, then suspended until reloaded
	assign tick = running && (count == '0);

	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			count <= '0;
			running <= 1'b0;
		end else if (load) begin
			count <= load_value;
			running <= 1'b1;
		end else if (tick) begin
			running <= 1'b0;
		end else if (running) begin
			count <= count - 1'b1;
		end
	end

endmodule : ims_rate_counter
`default_nettype wire

// ---- dv/ims_chk.sv ----
// checker for the sequencer's software and pad ports
// assumes: bound to ims_core, watches the mclk domain only
`timescale 1ns/1ns
`default_nettype none
module ims_chk (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic port_enable_bit,
	input wire logic [ims_pkg::MODE_W-1:0] mode_select_bits,
	input wire logic control_two_wr,
	input wire logic [ims_pkg::CTL2_LOW_W-1:0] control_two_wdata,
	input wire logic shift_buffer_wr,
	input wire logic serial_irq_flag,
	input wire logic write_collision_flag,
	input wire logic bus_collision_flag,
	input wire logic begin_detected,
	input wire logic halt_detected,
	input wire logic buffer_full,
	input wire logic start_trigger,
	input wire logic restart_trigger,
	input wire logic scl_oe,
	input wire logic sda_oe
);
	import ims_pkg::*;
	// ****
	// properties
	// ****
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire master = port_enable_bit && mode_select_bits == MODE_MASTER;
	sequence s_byte_end;
		$fell(buffer_full) ##[1:600] $rose(serial_irq_flag);
	endsequence
	a_flags_clear: assert property ($fell(port_enable_bit) |-> ##[1:4] (!begin_detected && !halt_detected))
		else $error("begin or halt kept after disable");
	a_write_collision_flag_busy: assert property (shift_buffer_wr && master && (start_trigger || restart_trigger || buffer_full)
		|=> write_collision_flag) else $error("busy write not flagged");
	a_write_collision_flag_cause: assert property ($rose(write_collision_flag) |-> $past(shift_buffer_wr))
		else $error("collision flag without write");
	a_write_taken: assert property (shift_buffer_wr && master && !control_two_wr
		|=> buffer_full || write_collision_flag) else $error("write neither taken nor flagged");
	a_start_cause: assert property ($rose(start_trigger) |-> $past(control_two_wr) && $past(control_two_wdata[0]))
		else $error("start without command");
	a_ctl2_busy: assert property (control_two_wr && start_trigger |=> !restart_trigger)
		else $error("restart taken while busy");
	a_start_irq: assert property ($fell(start_trigger) && master && $past(master)
		|-> serial_irq_flag || bus_collision_flag) else $error("start ended silently");
	a_start_hold: assert property ($fell(start_trigger) && port_enable_bit && serial_irq_flag && !bus_collision_flag
		|-> sda_oe) else $error("sda not held after start");
	a_byte_scl: assert property (s_byte_end |-> ##3 scl_oe [*4])
		else $error("scl not held after byte");
	a_bcol_cause: assert property ($rose(bus_collision_flag) |-> $past(start_trigger || restart_trigger))
		else $error("bus collision outside start");
	a_oe_release: assert property ($fell(port_enable_bit) |-> ##[1:30] (!scl_oe && !sda_oe))
		else $error("pads driven while disabled");
endmodule : ims_chk
bind ims_core ims_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .port_enable_bit(port_enable_bit),
	.mode_select_bits(mode_select_bits), .control_two_wr(control_two_wr), .control_two_wdata(control_two_wdata),
	.shift_buffer_wr(shift_buffer_wr), .serial_irq_flag(serial_irq_flag), .write_collision_flag(write_collision_flag),
	.bus_collision_flag(bus_collision_flag), .begin_detected(begin_detected), .halt_detected(halt_detected),
	.buffer_full(buffer_full), .start_trigger(start_trigger), .restart_trigger(restart_trigger),
	.scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire

// ---- dv/ims_target_model.sv ----
// i2c target model: pull-ups, byte capture, ack, stretch, line jam
// assumes: enables high while the master pulls a line low
`timescale 1ns/1ns
`default_nettype none
module ims_target_model (
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic ack_en,
	input wire logic stretch,
	input wire logic jam,
	output wire logic scl,
	output wire logic sda,
	output logic [7:0] got
);
	// ****
	// bus behaviour
	// ****
	logic [7:0] rx = 8'h00;
	logic [3:0] cnt = 4'h0;
	logic ack_low = 1'b0;
	logic str_low = 1'b0;
	int starts = 0;
	int seen = 0;
	initial got = 8'h00;
	// released lines float high
	assign scl = !(scl_oe || jam || str_low);
	assign sda = !(sda_oe || jam || ack_low);
	always @(negedge sda) begin
		if (scl) starts = starts + 1;
	end
	always @(posedge scl) begin
		if (starts != seen) begin
			cnt = 4'h0;
			seen = starts;
		end
		if (cnt < 4'h8) rx = {rx[6:0], sda};
		if (cnt == 4'h8) got = rx;
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end
	always @(negedge scl) begin
		ack_low = (cnt == 4'h8) && ack_en;
		if (stretch) begin
			str_low = 1'b1;
			#1000;
			str_low = 1'b0;
		end
	end
endmodule : ims_target_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// bench: software port sequences against a target model on the pads
// assumes: ims_core, its package, ims_target_model, ims_chk bound
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ims_pkg::*;
	// ****
	// stimulus and checks
	// ****
	logic mclk = 1'b0;
	logic link_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic port_enable_bit = 1'b0;
	logic [MODE_W-1:0] mode_select_bits = MODE_MASTER;
	logic [RATE_W-1:0] rate_reload_value = 8'h03;
	logic control_two_wr = 1'b0;
	logic [CTL2_LOW_W-1:0] control_two_wdata = 5'h00;
	logic shift_buffer_wr = 1'b0;
	logic [BYTE_W-1:0] shift_buffer_wdata = 8'h00;
	logic serial_irq_clr = 1'b0, write_collision_clr = 1'b0, bus_collision_clr = 1'b0;
	logic fw_scl_low = 1'b0, fw_sda_low = 1'b0, ack_en = 1'b1, stretch = 1'b0, jam = 1'b0;
	logic serial_irq_flag, write_collision_flag, bus_collision_flag, begin_detected, halt_detected;
	logic buffer_full, ack_result, start_trigger, restart_trigger, scl_oe, sda_oe;
	wire scl;
	wire sda;
	logic [7:0] got;
	int error_cnt = 0;
	int cmp_count = 0;
	always #10 mclk = ~mclk;
	initial begin
		#7;
		forever #32 link_clk = ~link_clk;
	end
	ims_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk), .port_enable_bit(port_enable_bit),
		.mode_select_bits(mode_select_bits), .rate_reload_value(rate_reload_value),
		.control_two_wr(control_two_wr), .control_two_wdata(control_two_wdata), .shift_buffer_wr(shift_buffer_wr),
		.shift_buffer_wdata(shift_buffer_wdata), .serial_irq_clr(serial_irq_clr),
		.write_collision_clr(write_collision_clr), .bus_collision_clr(bus_collision_clr), .fw_scl_low(fw_scl_low),
		.fw_sda_low(fw_sda_low), .serial_irq_flag(serial_irq_flag), .write_collision_flag(write_collision_flag),
		.bus_collision_flag(bus_collision_flag), .begin_detected(begin_detected), .halt_detected(halt_detected),
		.buffer_full(buffer_full), .ack_result(ack_result), .start_trigger(start_trigger),
		.restart_trigger(restart_trigger), .scl_in(scl), .sda_in(sda), .scl_out(), .scl_oe(scl_oe), .sda_out(),
		.sda_oe(sda_oe));
	ims_target_model u_target (.scl_oe(scl_oe), .sda_oe(sda_oe), .ack_en(ack_en), .stretch(stretch), .jam(jam),
		.scl(scl), .sda(sda), .got(got));
	task automatic results;
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic ctl2(input logic [4:0] d);
		@(posedge mclk);
		control_two_wr <= 1'b1;
		control_two_wdata <= d;
		@(posedge mclk);
		control_two_wr <= 1'b0;
	endtask : ctl2
	task automatic wrbuf(input logic [7:0] b);
		@(posedge mclk);
		shift_buffer_wr <= 1'b1;
		shift_buffer_wdata <= b;
		@(posedge mclk);
		shift_buffer_wr <= 1'b0;
	endtask : wrbuf
	task automatic clr;
		@(posedge mclk);
		{serial_irq_clr, write_collision_clr, bus_collision_clr} <= 3'h7;
		@(posedge mclk);
		{serial_irq_clr, write_collision_clr, bus_collision_clr} <= 3'h0;
	endtask : clr
	task automatic wait_done;
		int n = 0;
		while (serial_irq_flag !== 1'b1 && bus_collision_flag !== 1'b1 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		chk("completion", 8'h01, {7'h00, n < 3000});
		// let link-side status catch up
		repeat (8) @(negedge mclk);
	endtask : wait_done
	task automatic tx_byte(input logic [7:0] b, input logic ack, input logic str, input logic dbl);
		@(posedge mclk);
		ack_en <= ack;
		stretch <= str;
		wrbuf(b);
		if (dbl) wrbuf(~b);
		repeat (2) @(negedge mclk);
		chk("buffer_full", 8'h01, buffer_full);
		if (dbl) chk("write_collision_flag", 8'h01, write_collision_flag);
		wait_done();
		chk("target byte", b, got);
		chk("ack_result", !ack, ack_result);
		chk("buffer_full", 8'h00, buffer_full);
		chk("scl_oe", 8'h01, scl_oe);
		chk("serial_irq_flag", 8'h01, serial_irq_flag);
		clr();
	endtask : tx_byte
	initial begin
		#400000;
		error_cnt++;
		results();
	end
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(negedge mclk);
		chk("flags", 8'h00, {serial_irq_flag, write_collision_flag, bus_collision_flag, begin_detected,
			halt_detected, buffer_full, ack_result, start_trigger});
		ctl2(5'h01);
		repeat (2) @(negedge mclk);
		chk("start_trigger", 8'h00, start_trigger);
		@(posedge mclk);
		port_enable_bit <= 1'b1;
		repeat (10) @(posedge mclk);
		ctl2(5'h03);
		wrbuf(8'h55);
		ctl2(5'h02);
		repeat (2) @(negedge mclk);
		chk("start_trigger", 8'h01, start_trigger);
		chk("restart_trigger", 8'h00, restart_trigger);
		chk("write_collision_flag", 8'h01, write_collision_flag);
		wait_done();
		chk("start_trigger", 8'h00, start_trigger);
		chk("begin_detected", 8'h01, begin_detected);
		chk("sda_oe", 8'h01, sda_oe);
		chk("serial_irq_flag", 8'h01, serial_irq_flag);
		chk("restart_trigger", 8'h00, restart_trigger);
		clr();
		tx_byte(8'ha4, 1'b1, 1'b0, 1'b1);
		tx_byte(8'h3c, 1'b0, 1'b1, 1'b0);
		ctl2(5'h02);
		@(negedge mclk);
		chk("restart_trigger", 8'h01, restart_trigger);
		wait_done();
		chk("restart_trigger", 8'h00, restart_trigger);
		chk("begin_detected", 8'h01, begin_detected);
		chk("sda_oe", 8'h01, sda_oe);
		clr();
		tx_byte(8'ha5, 1'b1, 1'b0, 1'b0);
		@(posedge mclk);
		port_enable_bit <= 1'b0;
		jam <= 1'b1;
		repeat (30) @(negedge mclk);
		chk("begin_detected", 8'h00, begin_detected);
		chk("halt_detected", 8'h00, halt_detected);
		@(posedge mclk);
		port_enable_bit <= 1'b1;
		repeat (10) @(posedge mclk);
		ctl2(5'h01);
		wait_done();
		chk("bus_collision_flag", 8'h01, bus_collision_flag);
		chk("serial_irq_flag", 8'h00, serial_irq_flag);
		chk("start_trigger", 8'h00, start_trigger);
		clr();
		@(posedge mclk);
		mode_select_bits <= MODE_FW_MASTER;
		jam <= 1'b0;
		repeat (40) @(posedge mclk);
		clr();
		fw_sda_low <= 1'b1;
		repeat (40) @(negedge mclk);
		chk("sda_oe", 8'h01, sda_oe);
		chk("begin_detected", 8'h01, begin_detected);
		chk("serial_irq_flag", 8'h01, serial_irq_flag);
		@(posedge mclk);
		fw_sda_low <= 1'b0;
		repeat (40) @(negedge mclk);
		chk("halt_detected", 8'h01, halt_detected);
		results();
	end
endmodule : tb_top
`default_nettype wire

// ---- inc/ims_pkg.sv ----
// constants and types shared by the i2c master sequencer files
// assumes: included before the core and its helper modules
package ims_pkg;

	// ****************************************
	// mode selection
	// ****************************************
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_FW_MASTER = 4'hb;
	localparam int MODE_W = 4;

	// ****************************************
	// second control register, low field
	// ****************************************
	localparam int CTL2_LOW_W = 5;
	localparam int CTL2_START = 0;
	localparam int CTL2_RESTART = 1;

	// ****************************************
	// widths and counts
	// ****************************************
	localparam int RATE_W = 8;
	localparam int BYTE_W = 8;
	localparam int BITCNT_W = 4;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BITCNT_RST = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] RELOAD_RST = 8'h00;

	// ****************************************
	// events from the link domain
	// ****************************************
	localparam int EV_DONE = 0;
	localparam int EV_BEGIN = 1;
	localparam int EV_HALT = 2;
	localparam int EV_BF = 3;
	localparam int EV_N = 4;

	// ****************************************
	// levels into the link domain
	// ****************************************
	localparam int LV_MASTER = 0;
	localparam int LV_FW = 1;
	localparam int LV_FW_SCL = 2;
	localparam int LV_FW_SDA = 3;
	localparam int LV_N = 4;

	typedef enum logic [1:0] {
		CMD_START,
		CMD_RESTART,
		CMD_TX
	} ims_cmd_t;

endpackage : ims_pkg
